// ---- src/jcr_buf2.sv ----
module jcr_buf2 (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               in_valid,
  output logic                    in_ready,
  input  jcr_pkg::jcr_word_type   in_word,
  output logic                    out_valid,
  input  wire logic               out_ready,
  output jcr_pkg::jcr_word_type   out_word
);

  jcr_pkg::jcr_word_type mem_r [2];
  logic                  wr_ptr_r;
  logic                  rd_ptr_r;
  logic [1:0]            count_r;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_word  = mem_r[rd_ptr_r];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= 2'(count_r + {1'b0, push} - {1'b0, pop});
    end
  end

endmodule : jcr_buf2

// ---- src/jcr_pkg.sv ----
package jcr_pkg;

  // TAP controller states (IEEE 1149.1)
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET_STATE, RUN_TEST_IDLE_STATE, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } jcr_tap_type;

  localparam int        IR_W        = 6;
  localparam int        WORD_W      = 16;
  localparam int        READ_W      = 32;
  localparam logic [5:0] INSN_CFG_IN  = 6'h05;
  localparam logic [5:0] INSN_CFG_OUT = 6'h04;
  localparam logic [5:0] INSN_BYPASS  = 6'h3f;
  localparam logic [5:0] IR_RESET     = 6'h3f;
  localparam logic [5:0] IR_CAPTURE   = 6'h01;

  typedef struct packed {
    logic [15:0] data;
  } jcr_word_type;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jcr_pins_type;

endpackage : jcr_pkg

// ---- src/jcr_top.sv ----
// Notes on behaviour
// - Input instruction 000101, output 000100; shifted least significant first.
// - Shift-DR data moves most significant bit first in and out.
// - Each word shifted into the input register goes to the packet processor unless the two-entry buffer is full.
// - Commands enter only through input register; readback leaves through output register.
// - Readable registers return contents; unreadable ones return zeros.
// - Both access registers are instruction-selected TAP data registers.
// - Output instruction: 32 shifted bits return the device condition register.
module jcr_top (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  jcr_pkg::jcr_pins_type      pins,
  output logic                       tdo,
  output logic                       tdo_oe,
  output jcr_pkg::jcr_word_type      pkt_word,
  output logic                       pkt_valid,
  input  wire logic                  pkt_ready,
  input  wire logic [31:0]           rd_data,
  input  wire logic                  rd_data_valid,
  output logic                       rd_req,
  output jcr_pkg::jcr_tap_type       tap_state,
  output logic [5:0]                 insn
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and TCK edge detection

  logic [1:0] tck_s_r;
  logic [1:0] tms_s_r;
  logic [1:0] tdi_s_r;
  logic       tck_d_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tck_s_r <= 2'h0;
      tms_s_r <= 2'h3;
      tdi_s_r <= 2'h0;
      tck_d_r <= 1'b0;
    end else begin
      tck_s_r <= {tck_s_r[0], pins.tck};
      tms_s_r <= {tms_s_r[0], pins.tms};
      tdi_s_r <= {tdi_s_r[0], pins.tdi};
      tck_d_r <= tck_s_r[1];
    end
  end

  wire tck_rise = tck_s_r[1] && !tck_d_r;
  wire tck_fall = !tck_s_r[1] && tck_d_r;
  wire tms      = tms_s_r[1];
  wire tdi      = tdi_s_r[1];

  ////////////////////////////////////////////////////////////////////////
  // TAP controller; host navigation is its own duty

  jcr_pkg::jcr_tap_type st_r;
  jcr_pkg::jcr_tap_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      jcr_pkg::TEST_LOGIC_RESET_STATE: st_nxt = tms ? jcr_pkg::TEST_LOGIC_RESET_STATE : jcr_pkg::RUN_TEST_IDLE_STATE;
      jcr_pkg::RUN_TEST_IDLE_STATE:    st_nxt = tms ? jcr_pkg::SEL_DR : jcr_pkg::RUN_TEST_IDLE_STATE;
      jcr_pkg::SEL_DR:                 st_nxt = tms ? jcr_pkg::SEL_IR : jcr_pkg::CAP_DR;
      jcr_pkg::CAP_DR:                 st_nxt = tms ? jcr_pkg::EX1_DR : jcr_pkg::SHF_DR;
      jcr_pkg::SHF_DR:                 st_nxt = tms ? jcr_pkg::EX1_DR : jcr_pkg::SHF_DR;
      jcr_pkg::EX1_DR:                 st_nxt = tms ? jcr_pkg::UPD_DR : jcr_pkg::PAU_DR;
      jcr_pkg::PAU_DR:                 st_nxt = tms ? jcr_pkg::EX2_DR : jcr_pkg::PAU_DR;
      jcr_pkg::EX2_DR:                 st_nxt = tms ? jcr_pkg::UPD_DR : jcr_pkg::SHF_DR;
      jcr_pkg::UPD_DR:                 st_nxt = tms ? jcr_pkg::SEL_DR : jcr_pkg::RUN_TEST_IDLE_STATE;
      jcr_pkg::SEL_IR:                 st_nxt = tms ? jcr_pkg::TEST_LOGIC_RESET_STATE : jcr_pkg::CAP_IR;
      jcr_pkg::CAP_IR:                 st_nxt = tms ? jcr_pkg::EX1_IR : jcr_pkg::SHF_IR;
      jcr_pkg::SHF_IR:                 st_nxt = tms ? jcr_pkg::EX1_IR : jcr_pkg::SHF_IR;
      jcr_pkg::EX1_IR:                 st_nxt = tms ? jcr_pkg::UPD_IR : jcr_pkg::PAU_IR;
      jcr_pkg::PAU_IR:                 st_nxt = tms ? jcr_pkg::EX2_IR : jcr_pkg::PAU_IR;
      jcr_pkg::EX2_IR:                 st_nxt = tms ? jcr_pkg::UPD_IR : jcr_pkg::SHF_IR;
      jcr_pkg::UPD_IR:                 st_nxt = tms ? jcr_pkg::SEL_DR : jcr_pkg::RUN_TEST_IDLE_STATE;
      default:                         st_nxt = jcr_pkg::TEST_LOGIC_RESET_STATE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= jcr_pkg::TEST_LOGIC_RESET_STATE;
    end else if (tck_rise) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Instruction register, shifted least significant bit first

  logic [5:0] ir_sh_r;
  logic [5:0] ir_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ir_sh_r <= jcr_pkg::IR_CAPTURE;
      ir_r    <= jcr_pkg::IR_RESET;
    end else if (tck_rise) begin
      case (st_r)
        jcr_pkg::TEST_LOGIC_RESET_STATE: ir_r <= jcr_pkg::IR_RESET;
        jcr_pkg::CAP_IR: ir_sh_r <= jcr_pkg::IR_CAPTURE;
        jcr_pkg::SHF_IR: ir_sh_r <= {tdi, ir_sh_r[5:1]};
        jcr_pkg::UPD_IR: ir_r <= ir_sh_r;
        default: ;
      endcase
    end
  end

  wire sel_in  = (ir_r == jcr_pkg::INSN_CFG_IN);
  wire sel_out = (ir_r == jcr_pkg::INSN_CFG_OUT);

  ////////////////////////////////////////////////////////////////////////
  // Data registers: input word assembly, output readback, bypass

  logic [15:0] in_sh_r;
  logic [3:0]  in_cnt_r;
  logic [31:0] out_sh_r;
  logic        byp_r;
  logic        push_r;
  jcr_pkg::jcr_word_type push_word_r;
  logic                  buf_out_valid;
  jcr_pkg::jcr_word_type buf_out_word;
  wire                   buf_take = !pkt_valid || pkt_ready;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      in_sh_r     <= 16'h0000;
      in_cnt_r    <= 4'h0;
      push_r      <= 1'b0;
      push_word_r <= '0;
    end else begin
      push_r <= 1'b0;
      if (tck_rise && sel_in) begin
        if (st_r == jcr_pkg::CAP_DR) begin
          in_cnt_r <= 4'h0;
        end else if (st_r == jcr_pkg::SHF_DR) begin
          // Most significant bit arrives first, so shift towards the top
          in_sh_r  <= {in_sh_r[14:0], tdi};
          in_cnt_r <= 4'(in_cnt_r + 4'h1);
          if (in_cnt_r == 4'hf) begin
            push_r           <= 1'b1;
            push_word_r.data <= {in_sh_r[14:0], tdi};
          end
        end
      end
    end
  end

  // A word arriving while the buffer is full is dropped; at one TCK per 16 core
  // cycles the two-entry buffer only fills if the packet processor stalls long.
  jcr_buf2 i_jcr_buf2 (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .in_valid  (push_r),
    .in_ready  (),
    .in_word   (push_word_r),
    .out_valid (buf_out_valid),
    .out_ready (buf_take),
    .out_word  (buf_out_word)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pkt_valid <= 1'b0;
      pkt_word  <= '0;
    end else if (buf_take) begin
      pkt_valid <= buf_out_valid;
      pkt_word  <= buf_out_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out_sh_r <= 32'h0000_0000;
      byp_r    <= 1'b0;
      rd_req   <= 1'b0;
    end else begin
      if (tck_rise && sel_out && st_r == jcr_pkg::CAP_DR) begin
        // Unreadable targets yield zeros rather than their contents
        out_sh_r <= rd_data_valid ? rd_data : 32'h0000_0000;
        rd_req   <= 1'b1;
      end else begin
        rd_req <= 1'b0;
        if (tck_rise && sel_out && st_r == jcr_pkg::SHF_DR) begin
          out_sh_r <= {out_sh_r[30:0], 1'b0};
        end
      end
      if (tck_rise && !sel_in && !sel_out) begin
        if (st_r == jcr_pkg::CAP_DR) begin
          byp_r <= 1'b0;
        end else if (st_r == jcr_pkg::SHF_DR) begin
          byp_r <= tdi;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // TDO changes on the falling TCK edge as the standard requires

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tdo       <= 1'b0;
      tdo_oe    <= 1'b0;
      tap_state <= jcr_pkg::TEST_LOGIC_RESET_STATE;
      insn      <= jcr_pkg::IR_RESET;
    end else begin
      tap_state <= st_r;
      insn      <= ir_r;
      if (tck_fall) begin
        tdo_oe <= (st_r == jcr_pkg::SHF_IR) || (st_r == jcr_pkg::SHF_DR);
        if (st_r == jcr_pkg::SHF_IR) begin
          tdo <= ir_sh_r[0];
        end else if (sel_out) begin
          tdo <= out_sh_r[31];
        end else if (sel_in) begin
          tdo <= in_sh_r[15];
        end else begin
          tdo <= byp_r;
        end
      end
    end
  end

endmodule : jcr_top

// ---- verif/jcr_host.sv ----
module jcr_host (
  input wire logic                  core_clk,
  input wire logic                  tdo,
  output jcr_pkg::jcr_pins_type     pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] got;
  initial pins = '0;
  // One 160 ns TCK period; TCK rests low between steps, TDO taken before the rise
  task automatic step(input logic tms, input logic tdi);
    pins.tms = tms;
    pins.tdi = tdi;
    repeat (8) @(negedge core_clk);
    got = {got[30:0], tdo};
    pins.tck = 1'b1;
    repeat (8) @(negedge core_clk);
    pins.tck = 1'b0;
  endtask : step
  task automatic nav(input logic [7:0] tms, input int n);
    for (int i = 0; i < n; i++) step(tms[i], 1'b0);
  endtask : nav
  // Ends in the exit state after the data shift
  task automatic access(input logic [5:0] code, input logic [63:0] d, input int n);
    nav(8'h1f, 5);
    nav(8'h06, 5);
    for (int i = 0; i < 6; i++) step(i == 5, code[i]);
    nav(8'h03, 4);
    for (int i = n - 1; i >= 0; i--) step(i == 0, d[i]);
  endtask : access
endmodule : jcr_host

// ---- verif/jcr_top_bench.sv ----
module jcr_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  core_clk, sys_rst, tdo, tdo_oe, pkt_valid, pkt_ready, rd_data_valid, rd_req;
  logic [31:0]           rd_data;
  logic [5:0]            insn;
  jcr_pkg::jcr_pins_type pins;
  jcr_pkg::jcr_word_type pkt_word;
  jcr_pkg::jcr_tap_type  tap_state;
  logic [15:0]           got_q[$];
  logic [15:0]           exp_w[5] = '{16'haa99, 16'h5566, 16'h2901, 16'h2000, 16'h2000};
  int                    fail_count, n_tests, n_rd_req;
  `define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
    $display("BAD %0t got %h exp %h", $time, a, e); end end
  jcr_top i_jcr_top (.core_clk, .sys_rst, .pins, .tdo, .tdo_oe, .pkt_word, .pkt_valid, .pkt_ready,
    .rd_data, .rd_data_valid, .rd_req, .tap_state, .insn);
  jcr_host i_jcr_host (.core_clk, .tdo, .pins);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (pkt_valid && pkt_ready) got_q.push_back(pkt_word.data);
  always @(posedge core_clk) if (rd_req) n_rd_req++;
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic t_reset;
    `CHK(tap_state, jcr_pkg::TEST_LOGIC_RESET_STATE)
    `CHK(insn, jcr_pkg::IR_RESET)
    `CHK(tdo_oe, 1'b0)
  endtask : t_reset
  // Two words held back by a stalled processor, then three more with no stall
  task automatic t_cfg_in;
    pkt_ready = 1'b0;
    i_jcr_host.access(jcr_pkg::INSN_CFG_IN, {32'h0, 16'haa99, 16'h5566}, 32);
    `CHK(insn, jcr_pkg::INSN_CFG_IN)
    i_jcr_host.nav(8'h1f, 5);
    repeat (4) @(negedge core_clk);
    `CHK(tap_state, jcr_pkg::TEST_LOGIC_RESET_STATE)
    `CHK(got_q.size(), 0)
    pkt_ready = 1'b1;
    i_jcr_host.access(jcr_pkg::INSN_CFG_IN, {16'h0, 16'h2901, 16'h2000, 16'h2000}, 48);
    i_jcr_host.nav(8'h1f, 5);
    `CHK(got_q.size(), 5)
    for (int i = 0; i < 5; i++) `CHK(got_q[i], exp_w[i])
  endtask : t_cfg_in
  // Readable value comes back MSB first; unreadable gives zeros; no packet words
  task automatic t_cfg_out(input logic ok, input logic [31:0] v);
    rd_data = v;
    rd_data_valid = ok;
    n_rd_req = 0;
    i_jcr_host.access(jcr_pkg::INSN_CFG_OUT, 64'h0, 32);
    `CHK(insn, jcr_pkg::INSN_CFG_OUT)
    `CHK(i_jcr_host.got, ok ? v : 32'h0)
    `CHK(got_q.size(), 5)
    `CHK(n_rd_req, 1)
    rd_data = ~v;
    i_jcr_host.nav(8'h1f, 5);
  endtask : t_cfg_out
  // Bypass returns TDI one bit late behind a captured zero; no words, no reads
  task automatic t_bypass;
    n_rd_req = 0;
    i_jcr_host.access(jcr_pkg::INSN_BYPASS, {32'h0, 32'h9e37_79b9}, 32);
    `CHK(insn, jcr_pkg::INSN_BYPASS)
    `CHK(i_jcr_host.got, 32'h4f1b_bcdc)
    `CHK(got_q.size(), 5)
    `CHK(n_rd_req, 0)
    i_jcr_host.nav(8'h1f, 5);
  endtask : t_bypass
  initial begin
    #600000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    sys_rst = 1'b1;
    pkt_ready = 1'b1;
    rd_data = 32'h0;
    rd_data_valid = 1'b0;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge core_clk);
    t_reset();
    t_cfg_in();
    t_cfg_out(1'b1, 32'hc3a5_0f81);
    t_cfg_out(1'b0, 32'h5a3c_e718);
    t_bypass();
    report_and_stop();
  end
endmodule : jcr_top_bench

// ---- verif/jcr_top_properties.sv ----
module jcr_top_properties (
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  input wire logic                  tdo_oe,
  input jcr_pkg::jcr_word_type      pkt_word,
  input wire logic                  pkt_valid,
  input wire logic                  pkt_ready,
  input wire logic                  rd_req,
  input jcr_pkg::jcr_tap_type       tap_state,
  input wire logic [5:0]            insn
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_pkt_held_stall: assert property (pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_word))
    else $error("packet word dropped or changed while stalled");
  a_rd_req_single: assert property (rd_req |=> !rd_req)
    else $error("read request longer than one cycle");
  a_rd_req_capture: assert property (rd_req |-> tap_state == jcr_pkg::CAP_DR && insn == jcr_pkg::INSN_CFG_OUT)
    else $error("read request outside output capture");
  // Output enable follows the falling TCK edge, so it lags the state by half a TCK period
  a_oe_in_shift: assert property ($rose(tdo_oe) |-> tap_state inside {jcr_pkg::SHF_IR, jcr_pkg::SHF_DR})
    else $error("tdo enabled outside shift");
  a_oe_off_exit: assert property ($fell(tdo_oe) |-> !(tap_state inside {jcr_pkg::SHF_IR, jcr_pkg::SHF_DR}))
    else $error("tdo released inside shift");
  a_oe_idle_off: assert property ((tap_state == jcr_pkg::RUN_TEST_IDLE_STATE)[*2] |-> !tdo_oe)
    else $error("tdo driven while idle");
  a_reset_values: assert property ($fell(sys_rst) |-> tap_state == jcr_pkg::TEST_LOGIC_RESET_STATE
                                   && insn == jcr_pkg::IR_RESET && !pkt_valid && !rd_req)
    else $error("wrong values after reset");
  a_insn_update: assert property ($changed(insn) |-> tap_state inside {jcr_pkg::UPD_IR, jcr_pkg::TEST_LOGIC_RESET_STATE}
                                  || $past(tap_state) inside {jcr_pkg::UPD_IR, jcr_pkg::TEST_LOGIC_RESET_STATE})
    else $error("instruction changed outside update");
  a_pkt_from_in: assert property ($rose(pkt_valid) |-> insn == jcr_pkg::INSN_CFG_IN)
    else $error("packet word without input instruction");
  // TCK half period is at least four core cycles, so the state cannot step faster
  a_tap_step_rate: assert property ($changed(tap_state) |=> $stable(tap_state)[*4])
    else $error("tap state stepped too fast");
  c_rd: cover property (rd_req);
  c_pkt: cover property (pkt_valid && pkt_ready);
  c_shift_ir: cover property (tap_state == jcr_pkg::SHF_IR);
  c_oe: cover property ($rose(tdo_oe));
endmodule : jcr_top_properties

bind jcr_top jcr_top_properties i_jcr_top_properties (.core_clk, .sys_rst, .tdo_oe, .pkt_word, .pkt_valid,
  .pkt_ready, .rd_req, .tap_state, .insn);
